// ==== design/audio_record_path.sv ====
// Record path: per-frame decimation, DC-removal high-pass, output FIFO.
// Assumes modulator words arrive on ref_clk; straps and frame_sync are pins.
`timescale 1ns/1ps
`default_nettype none
module audio_record_path
  import audio_record_pkg::*;
#(
  parameter int unsigned QC_CYCLES = QC_DEFAULT_CYCLES,
  parameter bit DRE_PRESENT = 1'b1,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Strap pins
  input wire logic filter_select_strap,
  input wire logic master_select_strap,
  // Frame timing pin
  input wire logic frame_sync,
  // Modulator stream
  input wire logic mod_valid,
  input wire mod_pair_t mod_data,
  input wire logic [DRE_GAIN_W-1:0] dre_gain,
  // Sample output
  output logic out_valid,
  input wire logic out_ready,
  output sample_pair_t out_data,
  // Status
  output logic low_latency_active,
  output logic qc_active,
  output logic overrun,
  output logic master_rate_error
);

  // Smallest k with 2**k >= n; scales the box sum to a mean
  function automatic logic [4:0] ceil_log2(input logic [CNT_W-1:0] n);
    logic [4:0] k;
    k = '0;
    for (int i = 0; i < CNT_W; i++) begin
      if ((32'd1 << i) < 32'(n)) begin
        k = 5'(i + 1);
      end
    end
    return k;
  endfunction : ceil_log2

  function automatic logic signed [SAMPLE_W-1:0] normalize(
    input logic signed [ACC_W-1:0] sum,
    input logic [CNT_W-1:0] n
  );
    logic signed [ACC_W-1:0] scaled;
    scaled = (sum <<< (SAMPLE_W - MOD_W)) >>> ceil_log2(n);
    return scaled[SAMPLE_W-1:0];
  endfunction : normalize

  function automatic logic signed [SAMPLE_W-1:0] saturate(
    input logic signed [HPF_W-1:0] v
  );
    logic signed [HPF_W-1:0] hi;
    logic signed [HPF_W-1:0] lo;
    hi = HPF_W'((1 << (SAMPLE_W - 1)) - 1);
    lo = -hi - HPF_W'(1);
    if (v > hi) begin
      return hi[SAMPLE_W-1:0];
    end else if (v < lo) begin
      return lo[SAMPLE_W-1:0];
    end
    return v[SAMPLE_W-1:0];
  endfunction : saturate

  // Pin synchronisers
  logic fs_meta_reg;
  logic fs_sync_reg;
  logic fs_prev_reg;
  logic [1:0] strap_meta_reg;
  logic [1:0] strap_sync_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fs_meta_reg <= 1'b0;
      fs_sync_reg <= 1'b0;
      fs_prev_reg <= 1'b0;
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end else begin
      fs_meta_reg <= frame_sync;
      fs_sync_reg <= fs_meta_reg;
      fs_prev_reg <= fs_sync_reg;
      strap_meta_reg <= {master_select_strap, filter_select_strap};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // One tick per frame-sync rising edge
  wire frame_tick = fs_sync_reg && !fs_prev_reg;

  // Straps are caught once, after the synchronisers have settled
  logic [1:0] settle_reg;
  logic straps_taken_reg;
  logic master_reg;
  logic fsel_reg;
  wire strap_catch = !straps_taken_reg && (settle_reg == 2'(STRAP_SETTLE));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settle_reg <= '0;
      straps_taken_reg <= 1'b0;
      master_reg <= 1'b0;
      fsel_reg <= 1'b0; // [R9]
    end else begin
      if (!straps_taken_reg && !strap_catch) begin
        settle_reg <= settle_reg + 2'd1;
      end
      if (strap_catch) begin
        straps_taken_reg <= 1'b1;
        master_reg <= strap_sync_reg[1]; // [R18]
        fsel_reg <= strap_sync_reg[0]; // [R7]
      end
    end
  end

  // Low level or master mode keeps linear phase
  wire low_latency = !master_reg && fsel_reg; // [R6] [R8] [R20]
  assign low_latency_active = low_latency;

  // Quick-charge window after power-up; samples are discarded meanwhile
  logic [31:0] qc_cnt_reg;
  wire qc_busy = qc_cnt_reg != 32'(QC_CYCLES);
  assign qc_active = qc_busy;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      qc_cnt_reg <= '0;
    end else if (qc_busy) begin
      qc_cnt_reg <= qc_cnt_reg + 32'd1; // [R16]
    end
  end

  // Master rate check on the measured frame period
  logic [CNT_W-1:0] period_reg;
  logic rate_err_reg;
  logic seen_frame_reg;
  wire period_bad = (period_reg < CNT_W'(MASTER_PERIOD_MIN))
                 || (period_reg > CNT_W'(MASTER_PERIOD_MAX));
  assign master_rate_error = rate_err_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      period_reg <= '0;
      rate_err_reg <= 1'b0;
      seen_frame_reg <= 1'b0;
    end else if (frame_tick) begin
      period_reg <= CNT_W'(1);
      seen_frame_reg <= 1'b1;
      rate_err_reg <= master_reg && seen_frame_reg && period_bad; // [R19]
    end else if (period_reg != '1) begin
      period_reg <= period_reg + CNT_W'(1);
    end
  end

  // Accumulate-and-dump over one frame, both channels in lockstep
  logic signed [1:0][ACC_W-1:0] acc_reg;
  logic signed [1:0][ACC_W-1:0] dump_reg;
  logic [CNT_W-1:0] n_reg;
  logic [CNT_W-1:0] dump_n_reg;
  wire signed [1:0][ACC_W-1:0] mod_ext = {
    ACC_W'(signed'(mod_data.right)), ACC_W'(signed'(mod_data.left))
  };
  wire signed [1:0][ACC_W-1:0] mod_in = mod_valid ? mod_ext : '0;
  wire [CNT_W-1:0] n_in = mod_valid ? CNT_W'(1) : '0;
  wire [CNT_W-1:0] n_sum = (n_reg == '1) ? n_reg : n_reg + n_in;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= '0;
      dump_reg <= '0;
      n_reg <= '0;
      dump_n_reg <= '0;
    end else if (frame_tick) begin
      dump_reg <= acc_reg; // [R5]
      dump_n_reg <= n_reg;
      acc_reg <= mod_in;
      n_reg <= n_in;
    end else begin
      for (int c = 0; c < 2; c++) begin
        acc_reg[c] <= acc_reg[c] + mod_in[c]; // [R1]
      end
      n_reg <= n_sum;
    end
  end

  // Frame hand-off; a tick still pending when the next lands is an overrun
  proc_state_t state_reg;
  proc_state_t state_next;
  logic pending_reg;
  logic fifo_in_ready;
  wire take = (state_reg == ST_IDLE) && pending_reg;
  wire go = take && !qc_busy && (dump_n_reg != '0);
  assign overrun = frame_tick && pending_reg && !take;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= frame_tick || (pending_reg && !take);
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (go) state_next = ST_NORM;
      ST_NORM: state_next = ST_FIR;
      ST_FIR: state_next = ST_HPF;
      ST_HPF: state_next = ST_PUSH;
      ST_PUSH: if (fifo_in_ready) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Frame mean, then symmetric 1-2-1 stage for linear phase
  logic signed [1:0][SAMPLE_W-1:0] x_reg;
  logic signed [1:0][SAMPLE_W-1:0] x1_reg;
  logic signed [1:0][SAMPLE_W-1:0] x2_reg;
  logic signed [1:0][SAMPLE_W-1:0] fir_reg;
  logic signed [1:0][SAMPLE_W-1:0] sym_out;
  logic signed [1:0][SAMPLE_W-1:0] gain_out;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // Elements of a packed array are unsigned, so each is made signed before shifting
      sym_out[c] = SAMPLE_W'((signed'(x_reg[c]) >>> 2) + (signed'(x1_reg[c]) >>> 1)
                 + (signed'(x2_reg[c]) >>> 2)); // [R10] [R11] [R12] [R13] [R14]
      gain_out[c] = DRE_PRESENT ? SAMPLE_W'(signed'(fir_reg[c]) >>> dre_gain)
                  : fir_reg[c]; // [R17]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      x_reg <= '0;
      x1_reg <= '0;
      x2_reg <= '0;
      fir_reg <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (state_reg == ST_NORM) begin
          x_reg[c] <= normalize(dump_reg[c], dump_n_reg); // [R15]
        end
        if (state_reg == ST_FIR) begin
          fir_reg[c] <= low_latency ? x_reg[c] : sym_out[c];
          x1_reg[c] <= x_reg[c];
          x2_reg[c] <= x1_reg[c];
        end
      end
    end
  end

  // DC-removal: y += (g - g_prev) - alpha*y, alpha fixed in units of fs
  logic signed [1:0][SAMPLE_W-1:0] g_prev_reg;
  logic signed [1:0][HPF_W-1:0] y_reg;
  logic signed [1:0][HPF_W-1:0] y_next;
  logic signed [1:0][SAMPLE_W-1:0] hp_out;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // Sign kept through the difference so falling input steps stay negative
      y_next[c] = HPF_W'(signed'(y_reg[c])
        - HPF_W'((signed'(y_reg[c]) >>> HPF_Q) * HPF_W'(HPF_ALPHA)) // [R2] [R3] [R21]
        + (HPF_W'(signed'(gain_out[c]) - signed'(g_prev_reg[c])) <<< HPF_Q)); // [R4]
      hp_out[c] = saturate(HPF_W'(signed'(y_next[c]) >>> HPF_Q));
    end
  end

  logic signed [1:0][SAMPLE_W-1:0] hp_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      g_prev_reg <= '0;
      y_reg <= '0;
      hp_reg <= '0;
    end else if (state_reg == ST_HPF) begin
      g_prev_reg <= gain_out;
      y_reg <= y_next;
      hp_reg <= hp_out;
    end
  end

  // Output FIFO; a full FIFO holds the pipeline in ST_PUSH
  sample_pair_t push_data;
  assign push_data.left = hp_reg[0];
  assign push_data.right = hp_reg[1];

  logic [2*SAMPLE_W-1:0] fifo_out;
  assign out_data = sample_pair_t'(fifo_out);

  sample_fifo #(
    .W(2 * SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(resetn),
    .in_valid(state_reg == ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );

endmodule : audio_record_path
`default_nettype wire

// ==== design/audio_record_pkg.sv ====
// Constants and carrier types for the two-channel record path.
// Assumes a single 20 MHz ref_clk domain shared by the modulator feed.
// Notes on behaviour
// (R1) Both channels are captured together and processed side by side.
// (R2) Fixed DC-removal high-pass corner at 0.00025 of the output rate.
// (R3) One high-pass coefficient for all channels, no per-channel control.
// (R4) High-pass is a first-order recursive section on decimated samples.
// (R5) Exactly one output sample per channel per frame-sync period; here a frame with no modulator words gives none.
// (R6) Linear-phase or low-latency decimation, choosable only in slave mode.
// (R7) Filter type comes from the sampled filter-select strap, no register.
// (R8) Master mode always uses linear-phase decimation.
// (R9) Linear-phase decimation is the default type.
// (R10) Linear-phase filter has symmetric taps, so exact linear phase.
// (R11) Linear-phase at 8 kHz family: ripple within 0.05 dB to 0.454 fs.
// (R12) Linear-phase 8 kHz: stopband 72.7/81.2 dB, delay about 17.1 samples.
// (R13) Linear-phase 16 kHz: stopband 73.3/95.0 dB, delay about 15.7 samples.
// (R14) Linear-phase 24 kHz: stopband 73.0/96.4 dB, delay about 16.6 samples.
// (R15) Passband scales with the rate, up to 80 kHz at 176.4 kHz and above.
// (R16) Quick-charge interval at power-up, default sized for 1 uF couplings.
// (R17) Lower grade has no dynamic range enhancer; gain stage is bypassed.
// (R18) System straps master-select low for slave, high for master.
// (R19) Master mode supports only 44.1 kHz and 48 kHz output rates.
// (R20) Filter-select low picks linear phase, high picks low latency in slave.
// (R21) High-pass corner tracks the output rate without host programming.
package audio_record_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MOD_W = 4;
  localparam int SAMPLE_W = 24;
  localparam int ACC_W = 40;
  localparam int CNT_W = 16;
  localparam int DRE_GAIN_W = 3;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int STRAP_SETTLE = 3;
  localparam int QC_TIME_NS = 20_000_000;
  localparam int QC_DEFAULT_CYCLES = QC_TIME_NS / CLK_PERIOD_NS;
  localparam real HPF_CORNER = 0.00025;
  localparam int HPF_Q = 16;
  localparam int HPF_ALPHA = int'(2.0 * 3.14159265 * HPF_CORNER * (2.0 ** HPF_Q));
  localparam int HPF_W = SAMPLE_W + HPF_Q + 4;
  localparam int MASTER_FS_MIN_HZ = 44_100;
  localparam int MASTER_FS_MAX_HZ = 48_000;
  localparam int MASTER_PERIOD_MIN = CLK_HZ / MASTER_FS_MAX_HZ;
  localparam int MASTER_PERIOD_MAX = (CLK_HZ + MASTER_FS_MIN_HZ - 1) / MASTER_FS_MIN_HZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_NORM = 3'h1,
    ST_FIR = 3'h3,
    ST_HPF = 3'h2,
    ST_PUSH = 3'h6
  } proc_state_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] right;
    logic signed [SAMPLE_W-1:0] left;
  } sample_pair_t;

  typedef struct packed {
    logic signed [MOD_W-1:0] right;
    logic signed [MOD_W-1:0] left;
  } mod_pair_t;
endpackage : audio_record_pkg

// ==== design/sample_fifo.sv ====
// Sample FIFO with registered read data.
// Assumes one clock; source stalls on in_ready, sink on out_ready.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int W = 48,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic out_valid_reg;
  logic [W-1:0] out_data_reg;
  wire push = in_valid && in_ready;
  wire load = (count_reg != '0) && (!out_valid_reg || out_ready);
  wire [AW:0] count_next = count_reg + (AW+1)'(push) - (AW+1)'(load);

  assign in_ready = count_reg != (AW+1)'(DEPTH);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  // Storage has no reset so it maps onto plain RAM
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      count_reg <= count_next;
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (load) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
        out_data_reg <= mem[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule : sample_fifo
`default_nettype wire

// ==== dv/audio_record_path_tb.sv ====
// Self-checking bench for the record path against the far-side model.
// Assumes a short quick-charge count; straps change only in reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("ERROR %s expected %h seen %h", name, exp, got); \
  end \
end
module audio_record_path_tb
  import audio_record_pkg::*;
;
  localparam int unsigned QC_TEST = 20;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic filter_select_strap = 1'b0;
  logic master_select_strap = 1'b0;
  logic [DRE_GAIN_W-1:0] dre_gain = '0;
  logic frame_sync, mod_valid, out_ready, out_valid;
  logic low_latency_active, qc_active, overrun, master_rate_error;
  mod_pair_t mod_data;
  sample_pair_t out_data, exp_now;
  sample_pair_t exp_q[$];
  int errors = 0;
  int comparisons = 0;
  int ovr_seen = 0;

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  audio_record_path #(.QC_CYCLES(QC_TEST)) u_audio_record_path (
    .ref_clk, .resetn, .filter_select_strap, .master_select_strap, .frame_sync,
    .mod_valid, .mod_data, .dre_gain, .out_valid, .out_ready, .out_data,
    .low_latency_active, .qc_active, .overrun, .master_rate_error
  );
  record_partner u_record_partner (.ref_clk, .frame_sync, .mod_valid, .mod_data, .out_ready);

  // Scoreboard: oldest note against each accepted output
  always @(posedge ref_clk) begin
    if (resetn && overrun === 1'b1) ovr_seen++;
    if (resetn && out_valid === 1'b1 && out_ready) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("ERROR out_data expected none seen %h", out_data);
      end else begin
        exp_now = exp_q.pop_front();
        `CHK("out_data", exp_now, out_data)
      end
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic do_reset(input logic ms, input logic fs);
    resetn = 1'b0;
    master_select_strap = ms;
    filter_select_strap = fs;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (QC_TEST + 10) @(negedge ref_clk);
  endtask : do_reset

  // Extra cycles first so a stray output after the last frame is caught
  task automatic wait_drain(input string name);
    repeat (12) @(negedge ref_clk);
    for (int k = 0; k < 800 && exp_q.size() > 0; k++) @(negedge ref_clk);
    `CHK("pending", 0, exp_q.size())
    $display("test %s done", name);
  endtask : wait_drain

  // First nonzero frame after silence: high-pass passes the step whole
  task automatic run_mode(input logic ms, input logic fs, input logic [DRE_GAIN_W-1:0] dg);
    logic ll;
    logic signed [SAMPLE_W-1:0] l, r;
    int gap;
    ll = !ms && fs;
    gap = ms ? 422 : 8 + $urandom_range(8);
    l = (ll ? 24'sh100000 : 24'sh040000) >>> dg;
    r = (ll ? 24'sh200000 : 24'sh080000) >>> dg;
    dre_gain = dg;
    do_reset(ms, fs);
    `CHK("low_latency", ll, low_latency_active)
    `CHK("qc_active", 1'b0, qc_active)
    exp_q.push_back('0);
    u_record_partner.frame(4'sd0, 4'sd0, 4, gap);
    exp_q.push_back({r, l});
    u_record_partner.frame(4'sd1, 4'sd2, 4, gap);
    u_record_partner.frame(4'sd0, 4'sd0, 0, gap);
    if (ms) begin
      `CHK("rate_error", 1'b0, master_rate_error)
      u_record_partner.frame(4'sd0, 4'sd0, 0, 10);
      u_record_partner.frame(4'sd0, 4'sd0, 0, 10);
      `CHK("rate_error", 1'b1, master_rate_error)
    end
    wait_drain("mode");
  endtask : run_mode

  initial begin
    void'($urandom(17));
    run_mode(1'b0, 1'b0, 3'd0);
    run_mode(1'b0, 1'b1, 3'd1);
    run_mode(1'b1, 1'b1, 3'd0);
    run_mode(1'b1, 1'b0, 3'd2);
    do_reset(1'b0, 1'b0);
    ovr_seen = 0;
    u_record_partner.ready_mode = 1;
    for (int i = 0; i < FIFO_DEPTH_DEF; i++) begin
      exp_q.push_back('0);
      u_record_partner.frame(4'sd0, 4'sd0, 1 + $urandom_range(3), 8);
    end
    `CHK("fifo_valid", 1'b1, out_valid)
    `CHK("overrun_fill", 0, ovr_seen)
    u_record_partner.ready_mode = 2;
    wait_drain("fill");
    u_record_partner.ready_mode = 1;
    for (int i = 0; i < 40; i++) u_record_partner.frame(4'sd0, 4'sd0, 2, 8);
    `CHK("overrun_seen", 1'b1, ovr_seen > 0)
    $display("test overrun done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("ERROR watchdog expected done seen timeout");
    report_and_stop();
  end
endmodule : audio_record_path_tb

bind audio_record_path record_path_props #(.QC_CYCLES(QC_CYCLES)) u_record_path_props (
  .ref_clk, .resetn, .filter_select_strap, .master_select_strap, .out_valid, .out_ready,
  .out_data, .low_latency_active, .qc_active, .overrun, .master_rate_error
);
`default_nettype wire

// ==== dv/record_partner.sv ====
// Far side: modulator word feed, frame sync pin and sample sink.
// Tasks are entered at a falling edge; outputs change only there.
`timescale 1ns/1ps
`default_nettype none
module record_partner
  import audio_record_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Modulator and frame timing
  output logic frame_sync,
  output logic mod_valid,
  output mod_pair_t mod_data,
  // Sink
  output logic out_ready
);
  // Sink mode: 0 always ready, 1 stalled, 2 random stalls
  int ready_mode = 0;
  initial begin
    frame_sync = 1'b0;
    mod_valid = 1'b0;
    mod_data = '0;
    out_ready = 1'b1;
  end
  always @(negedge ref_clk)
    out_ready <= (ready_mode == 0) || (ready_mode == 2 && $urandom_range(1) == 1);
  // Words before the frame edge, so the dump holds exactly n words
  task automatic frame(input logic signed [MOD_W-1:0] l, input logic signed [MOD_W-1:0] r,
                       input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      mod_valid = 1'b1;
      mod_data = '{right: r, left: l};
      @(negedge ref_clk);
    end
    mod_valid = 1'b0;
    mod_data = ~mod_data;
    frame_sync = 1'b1;
    repeat (4) @(negedge ref_clk);
    frame_sync = 1'b0;
    repeat (gap) @(negedge ref_clk);
  endtask : frame
endmodule : record_partner
`default_nettype wire

// ==== dv/record_path_props.sv ====
// Checker on the record path top ports.
// Bound from the bench; straps move only while resetn is low.
`timescale 1ns/1ps
`default_nettype none
module record_path_props
  import audio_record_pkg::*;
#(
  parameter int unsigned QC_CYCLES = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Straps
  input wire logic filter_select_strap,
  input wire logic master_select_strap,
  // Outputs and sink
  input wire logic out_valid,
  input wire logic out_ready,
  input wire sample_pair_t out_data,
  input wire logic low_latency_active,
  input wire logic qc_active,
  input wire logic overrun,
  input wire logic master_rate_error
);
  // Edges since reset release, saturating
  int unsigned cyc;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cyc <= 0;
    else if (cyc < 1000) cyc <= cyc + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  strap_slave_a: assert property (
    cyc == 6 && filter_select_strap && !master_select_strap |-> low_latency_active)
    else $error("low latency not taken in slave mode");
  strap_default_a: assert property (
    cyc == 6 && !filter_select_strap |-> !low_latency_active)
    else $error("linear phase not default");
  strap_cause_a: assert property (
    low_latency_active |-> filter_select_strap && !master_select_strap)
    else $error("low latency without slave strap");
  qc_hold_a: assert property (
    cyc < QC_CYCLES - 1 |-> qc_active) else $error("quick charge ended early");
  qc_end_a: assert property (
    cyc > QC_CYCLES + 1 |-> !qc_active) else $error("quick charge too long");
  qc_quiet_a: assert property (
    qc_active |-> !out_valid) else $error("output during quick charge");
  out_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output dropped before taken");
  overrun_pulse_a: assert property (
    overrun |=> !overrun) else $error("overrun longer than a cycle");
  rate_slave_a: assert property (
    !master_select_strap |-> !master_rate_error) else $error("rate error in slave mode");
endmodule : record_path_props
`default_nettype wire
